/* File: bench/spm_pin_mux_asserts.sv */
`timescale 1ns/1ps
module spm_pin_mux_chk (
  input wire logic clock, // system clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic ce, // clock enable
  input wire logic [3:0] address, // byte address
  input wire logic read, // read request
  input wire logic write, // write request
  input wire logic [31:0] writedata, // write data
  input wire logic [3:0] byteenable, // write lanes
  input logic waitrequest, // bus stall
  input wire logic spi_chip_select_2, // spi select 2
  input wire logic spi_chip_select_1, // spi select 1
  input wire logic spi_chip_select_0, // spi select 0
  input wire logic spi_clock_out, // spi clock
  input wire logic spi_data_out, // spi data out
  input wire logic dma_acknowledge_3, // dma ack 3
  input wire logic pulse_output_3, // pwm 3
  input wire logic i2c_scl_drive_low, // i2c clock pull
  input logic [6:0] pin_out, // pad levels
  input logic [6:0] pin_oe_n // pad enables, active low
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic [15:0] sel_ff;
  logic [15:0] nxt_sel;
  // shadow of the select register, so pad checks need no bus reads
  always_comb begin
    nxt_sel = sel_ff;
    if (byteenable[0]) nxt_sel[7:0] = writedata[7:0];
    if (byteenable[1]) nxt_sel[15:8] = writedata[15:8];
  end
  // reset acts only with ce high, unlike the design, which resets whatever ce is
  always_ff @(posedge clock) begin
    if (!rst_n && ce) sel_ff <= 16'h0000;
    else if (ce && write && !waitrequest && address == 4'h0)
      sel_ff <= nxt_sel & spm_pkg::FUNC_SEL_WMASK;
  end
  sequence s_hold;
    waitrequest && (read || write);
  endsequence
  sequence s_ack;
    !waitrequest;
  endsequence
  a_bus_one_wait: assert property ($rose(read || write) |-> s_hold ##1 s_ack)
    else $error("bus answer not after exactly one wait cycle");
  a_cs3_dma_ack: assert property (ce && sel_ff[13:12] == 2'b01 |=>
    pin_out[6] == $past(dma_acknowledge_3) && !pin_oe_n[6])
    else $error("cs3 pin not dma acknowledge");
  a_cs3_pulse_out: assert property (ce && sel_ff[13:12] == 2'b10 |=>
    pin_out[6] == $past(pulse_output_3) && !pin_oe_n[6])
    else $error("cs3 pin not pulse output");
  a_cs2_spi_sel: assert property (ce && sel_ff[11:10] == 2'b11 |=>
    pin_out[5] == $past(spi_chip_select_2) && !pin_oe_n[5])
    else $error("cs2 pin not spi select");
  a_cs1_spi_sel: assert property (ce && sel_ff[9] |=>
    pin_out[4] == $past(spi_chip_select_1) && !pin_oe_n[4])
    else $error("cs1 pin not spi select");
  a_cs0_spi_sel: assert property (ce && sel_ff[7] |=>
    pin_out[3] == $past(spi_chip_select_0) && !pin_oe_n[3])
    else $error("cs0 pin not spi select");
  a_sck_spi_clk: assert property (ce && sel_ff[5:4] == 2'b11 |=>
    pin_out[2] == $past(spi_clock_out) && !pin_oe_n[2])
    else $error("clock pin not spi clock");
  a_sck_i2c_pull: assert property (ce && sel_ff[5:4] == 2'b10 |=>
    !pin_out[2] && pin_oe_n[2] == !$past(i2c_scl_drive_low))
    else $error("clock pin not i2c open drain");
  a_din_undriven: assert property (ce && sel_ff[3:2] == 2'b11 |=>
    pin_oe_n[1])
    else $error("data-in pin driven in spi role");
  a_dout_spi_out: assert property (ce && sel_ff[1] |=>
    pin_out[0] == $past(spi_data_out) && !pin_oe_n[0])
    else $error("data-out pin not spi data");
endmodule : spm_pin_mux_chk

bind spm_pin_mux spm_pin_mux_chk i_chk (.clock, .rst_n, .ce, .address, .read,
  .write, .writedata, .byteenable, .waitrequest, .spi_chip_select_2,
  .spi_chip_select_1, .spi_chip_select_0, .spi_clock_out, .spi_data_out,
  .dma_acknowledge_3, .pulse_output_3, .i2c_scl_drive_low, .pin_out,
  .pin_oe_n);

/* File: bench/spm_pin_mux_tb_top.sv */
`timescale 1ns/1ps
module spm_pin_mux_tb_top;
  logic clock, rst_n, ce, read, write, waitrequest;
  logic spi_data_in, i2c_scl_in, i2c_sda_in;
  logic [3:0] address, byteenable;
  logic [31:0] writedata, readdata, q;
  logic [11:0] per;
  logic [6:0] pin_in, pin_out, pin_oe_n;
  logic [15:0] v;
  int error_cnt = 0;
  int n_compared = 0;

  spm_pin_mux i_spm_pin_mux (.clock(clock), .rst_n(rst_n), .ce(ce),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .spi_chip_select_3(per[0]),
    .spi_chip_select_2(per[1]), .spi_chip_select_1(per[2]),
    .spi_chip_select_0(per[3]), .spi_clock_out(per[4]),
    .spi_data_out(per[5]), .spi_data_in(spi_data_in),
    .dma_acknowledge_3(per[6]), .dma_acknowledge_2(per[7]),
    .pulse_output_3(per[8]), .pulse_output_2(per[9]),
    .i2c_scl_drive_low(per[10]), .i2c_sda_drive_low(per[11]),
    .i2c_scl_in(i2c_scl_in), .i2c_sda_in(i2c_sda_in), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n));

  // 200 MHz system clock
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : report_and_stop

  // request stands until waitrequest is sampled low at a rising edge;
  // a hang is left to the watchdog
  task automatic bus_xfer(input logic wr, input logic [3:0] a,
                          input logic [31:0] d, input logic [3:0] be);
    address <= a;
    writedata <= d;
    byteenable <= be;
    read <= ~wr;
    write <= wr;
    @(posedge clock);
    while (waitrequest !== 1'b0) begin
      @(posedge clock);
    end
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clock);
  endtask : bus_xfer

  task automatic wr(input logic [3:0] a, input logic [31:0] d,
                    input logic [3:0] be);
    bus_xfer(1'b1, a, d, be);
  endtask : wr

  task automatic chk_rd(input logic [3:0] a, input logic [31:0] e);
    bus_xfer(1'b0, a, 32'h0000_0000, 4'hF);
    n_compared++;
    if (q !== e) begin
      error_cnt++;
      $display("MISMATCH %0t read %h got %h exp %h", $time, a, q, e);
    end
  endtask : chk_rd

  // levels of undriven pads are left out on purpose
  task automatic chk_pad(input logic [13:0] e);
    n_compared++;
    if (pin_oe_n !== e[13:7] || ((pin_out ^ e[6:0]) & ~e[13:7]) !== 7'h00)
    begin
      error_cnt++;
      $display("MISMATCH %0t pads %h %h exp %h", $time, pin_oe_n, pin_out, e);
    end
  endtask : chk_pad

  task automatic chk_bit(input logic got, input logic e);
    n_compared++;
    if (got !== e) begin
      error_cnt++;
      $display("MISMATCH %0t input bit %b exp %b", $time, got, e);
    end
  endtask : chk_bit

  // expected {oe_n, out} with all gpio pads set to drive g
  function automatic logic [13:0] exp_pads(input logic [15:0] s,
      input logic [11:0] p, input logic [6:0] g);
    logic [6:0] o, e;
    o = g;
    e = 7'h00;
    case (s[13:12])
      2'b01: o[6] = p[6];
      2'b10: o[6] = p[8];
      2'b11: o[6] = p[0];
      default: ;
    endcase
    case (s[11:10])
      2'b01: o[5] = p[7];
      2'b10: o[5] = p[9];
      2'b11: o[5] = p[1];
      default: ;
    endcase
    if (s[9]) o[4] = p[2];
    if (s[7]) o[3] = p[3];
    if (s[5:4] == 2'b10) begin
      o[2] = 1'b0;
      e[2] = ~p[10];
    end else if (s[5:4] == 2'b11) o[2] = p[4];
    if (s[3:2] == 2'b10) begin
      o[1] = 1'b0;
      e[1] = ~p[11];
    end else if (s[3:2] == 2'b11) e[1] = 1'b1;
    if (s[1]) o[0] = p[5];
    return {e, o};
  endfunction : exp_pads

  // watchdog, well beyond the roughly 120 cycles the tests need
  initial begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    $display("MISMATCH %0t watchdog expired", $time);
    report_and_stop();
  end

  // main sequence
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    address = 4'h0;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0000_0000;
    byteenable = 4'h0;
    per = 12'h000;
    pin_in = 7'h00;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    chk_pad({7'h7F, 7'h00});
    chk_rd(4'h0, 32'h0000_0000);
    chk_rd(4'h8, 32'h0000_0000);
    wr(4'h0, 32'hFFFF_FFFF, 4'hF);
    chk_rd(4'h0, 32'h0000_3EBE);
    wr(4'h8, 32'h0000_007F, 4'hF);
    wr(4'h4, 32'h0000_0055, 4'hF);
    chk_rd(4'h4, 32'h0000_0055);
    // every pair code, the two pins of a pair always on different codes
    for (int k = 0; k < 4; k++) begin
      v = {2'b00, k[1:0], ~k[1:0], k[0], 1'b0, k[1], 1'b0, k[1:0], ~k[1:0],
           k[0], 1'b0};
      wr(4'h0, {16'h0000, v}, 4'h3);
      for (int p = 0; p < 2; p++) begin
        per <= (p == 0) ? 12'hA5C : 12'h5A3;
        repeat (3) @(posedge clock);
        chk_pad(exp_pads(v, per, 7'h55));
      end
    end
    // lanes, unmapped and read-only places
    wr(4'h0, 32'h0000_0000, 4'h3);
    wr(4'h0, 32'hFFFF_FFFF, 4'h1);
    chk_rd(4'h0, 32'h0000_00BE);
    wr(4'h2, 32'hFFFF_FFFF, 4'hF);
    chk_rd(4'h2, 32'h0000_0000);
    wr(4'hC, 32'hFFFF_FFFF, 4'hF);
    wr(4'h0, 32'h0000_000C, 4'h3);
    pin_in <= 7'h02;
    repeat (4) @(posedge clock);
    chk_rd(4'hC, 32'h0000_0202);
    chk_bit(spi_data_in, 1'b1);
    chk_bit(i2c_sda_in, 1'b1);
    wr(4'h0, 32'h0000_0028, 4'h3);
    pin_in <= 7'h04;
    repeat (4) @(posedge clock);
    chk_rd(4'hC, 32'h0000_0604);
    chk_bit(i2c_sda_in, 1'b0);
    chk_bit(i2c_scl_in, 1'b1);
    chk_bit(spi_data_in, 1'b0);
    wr(4'h0, 32'h0000_0014, 4'h3);
    chk_rd(4'hC, 32'h0000_0004);
    report_and_stop();
  end
endmodule : spm_pin_mux_tb_top

/* File: core/spm_pin_cell.sv */
`timescale 1ns/1ps
// output stage of one pad: registered level and drive enable
module spm_pin_cell (
  input wire logic clock, // system clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic ce, // clock enable
  input wire logic nxt_level, // level the pad should show
  input wire logic nxt_drive, // high when the pad should be driven
  output logic pin_out, // pad output level
  output logic pin_oe_n // pad output enable, active low
);

  logic pin_out_ff;
  logic pin_oe_n_ff;

  // pads come out of reset undriven so no peripheral fights the board
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pin_out_ff <= 1'b0;
      pin_oe_n_ff <= 1'b1;
    end else if (ce) begin
      pin_out_ff <= nxt_level;
      pin_oe_n_ff <= ~nxt_drive;
    end
  end

  assign pin_out = pin_out_ff;
  assign pin_oe_n = pin_oe_n_ff;

endmodule : spm_pin_cell

/* File: core/spm_pin_mux.sv */
// Summary of operation
// - bits 13:10 pick gpio, dma ack, pulse output or spi for cs3/cs2
// - bit 9 set gives cs1 pin its spi chip select, clear gives gpio
// - bit 7 set gives cs0 pin its spi chip select, clear gives gpio
// - bits 5:2: 00/01 gpio, 10 i2c clock/data, 11 spi clock/data in
// - bit 1 set drives data-out pin from spi data out, else gpio
//
// The register offsets and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/1ps
module spm_pin_mux (
  input wire logic clock, // system clock, 200 MHz
  input wire logic rst_n, // synchronous reset, active low
  input wire logic ce, // clock enable, when low all state holds and only reset changes it
  // avalon-mm slave
  input wire logic [3:0] address, // byte address
  input wire logic read, // read request
  input wire logic write, // write request
  input wire logic [31:0] writedata, // write data
  input wire logic [3:0] byteenable, // byte lanes of a write
  output logic [31:0] readdata, // read data, registered
  output logic waitrequest, // high while the request is held
  // peripheral side
  input wire logic spi_chip_select_3, // spi controller chip select 3
  input wire logic spi_chip_select_2, // spi controller chip select 2
  input wire logic spi_chip_select_1, // spi controller chip select 1
  input wire logic spi_chip_select_0, // spi controller chip select 0
  input wire logic spi_clock_out, // spi controller serial clock
  input wire logic spi_data_out, // spi controller serial data out
  output logic spi_data_in, // serial data in to the spi controller
  input wire logic dma_acknowledge_3, // dma channel 3 acknowledge
  input wire logic dma_acknowledge_2, // dma channel 2 acknowledge
  input wire logic pulse_output_3, // pwm channel 3 output
  input wire logic pulse_output_2, // pwm channel 2 output
  input wire logic i2c_scl_drive_low, // i2c wants the clock line low
  input wire logic i2c_sda_drive_low, // i2c wants the data line low
  output logic i2c_scl_in, // i2c clock line level
  output logic i2c_sda_in, // i2c data line level
  // pads, index order dout, din, sck, cs0, cs1, cs2, cs3
  input wire logic [6:0] pin_in, // pad input levels
  output logic [6:0] pin_out, // pad output levels
  output logic [6:0] pin_oe_n // pad output enables, active low
);

  // software-visible registers
  logic [15:0] spi_pin_function_select_ff;
  logic [6:0] gpio_data_ff;
  logic [6:0] gpio_dir_ff;
  logic [31:0] readdata_ff;
  logic ack_ff;

  // synchronised pad levels
  logic [6:0] pin_sync;

  // role of every pin
  spm_pkg::spm_role_t cs3_pin_select;
  spm_pkg::spm_role_t cs2_pin_select;
  spm_pkg::spm_role_t cs1_pin_select;
  spm_pkg::spm_role_t cs0_pin_select;
  spm_pkg::spm_role_t serial_clock_pin_select;
  spm_pkg::spm_role_t data_in_pin_select;
  spm_pkg::spm_role_t data_out_pin_select;

  // what each pad should show next
  logic [6:0] nxt_level;
  logic [6:0] nxt_drive;
  logic [6:0] func_mask;

  // peripheral-side input registers
  logic spi_data_in_ff;
  logic i2c_scl_in_ff;
  logic i2c_sda_in_ff;

  // bus decode
  logic req;
  logic hit_func;
  logic hit_data;
  logic hit_dir;
  logic hit_state;
  logic [15:0] func_merged;
  logic [15:0] data_merged;
  logic [15:0] dir_merged;

  // ---------------------------------------------------------------
  // avalon-mm slave
  // ---------------------------------------------------------------

  // one wait cycle: readdata is loaded while waitrequest is high
  assign req = read | write;
  assign waitrequest = req & ~ack_ff;

  // full byte address match; misaligned or unknown offsets are unmapped
  assign hit_func = (address == spm_pkg::OFS_FUNC_SEL);
  assign hit_data = (address == spm_pkg::OFS_GPIO_DATA);
  assign hit_dir = (address == spm_pkg::OFS_GPIO_DIR);
  assign hit_state = (address == spm_pkg::OFS_PIN_STATE);

  // lane merges for the three writable registers
  assign func_merged = spm_pkg::lane_merge(spi_pin_function_select_ff,
                                           writedata, byteenable);
  assign data_merged = spm_pkg::lane_merge({9'h000, gpio_data_ff},
                                           writedata, byteenable);
  assign dir_merged = spm_pkg::lane_merge({9'h000, gpio_dir_ff},
                                          writedata, byteenable);

  // handshake flag: set on the first cycle, cleared when the master
  // sees waitrequest low and takes the answer
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ack_ff <= 1'b0;
    end else if (ce) begin
      ack_ff <= req & ~ack_ff;
    end
  end

  // read data captured in the wait cycle; unmapped offsets read zero
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      readdata_ff <= spm_pkg::READ_DATA_RESET;
    end else if (ce && read && !ack_ff) begin
      if (hit_func) begin
        readdata_ff <= {16'h0000, spi_pin_function_select_ff};
      end else if (hit_data) begin
        readdata_ff <= {25'h000_0000, gpio_data_ff};
      end else if (hit_dir) begin
        readdata_ff <= {25'h000_0000, gpio_dir_ff};
      end else if (hit_state) begin
        readdata_ff <= {16'h0000, 1'b0, func_mask, 1'b0, pin_sync};
      end else begin
        readdata_ff <= spm_pkg::READ_DATA_RESET;
      end
    end
  end

  assign readdata = readdata_ff;

  // function select register; reserved bits are masked so they read
  // zero even if software breaks the convention
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      spi_pin_function_select_ff <= spm_pkg::FUNC_SEL_RESET;
    end else if (ce && write && ack_ff && hit_func) begin
      spi_pin_function_select_ff <= func_merged &
                                    spm_pkg::FUNC_SEL_WMASK;
    end
  end

  // gpio output level register
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      gpio_data_ff <= spm_pkg::GPIO_DATA_RESET;
    end else if (ce && write && ack_ff && hit_data) begin
      gpio_data_ff <= data_merged[6:0];
    end
  end

  // gpio direction register, 1 drives the pad
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      gpio_dir_ff <= spm_pkg::GPIO_DIR_RESET;
    end else if (ce && write && ack_ff && hit_dir) begin
      gpio_dir_ff <= dir_merged[6:0];
    end
  end

  // ---------------------------------------------------------------
  // role decode
  // ---------------------------------------------------------------

  // paired fields: each half decoded on its own, so mixed codes give
  // each pin of the pair a different role, except 00 and 01 on clock/data in, both gpio
  assign cs3_pin_select = spm_pkg::cs_pair_role(
    spi_pin_function_select_ff[spm_pkg::CS3_SEL_HI:spm_pkg::CS3_SEL_LO]
  );
  assign cs2_pin_select = spm_pkg::cs_pair_role(
    spi_pin_function_select_ff[spm_pkg::CS2_SEL_HI:spm_pkg::CS2_SEL_LO]
  );
  assign cs1_pin_select = spm_pkg::bit_role(
    spi_pin_function_select_ff[spm_pkg::CS1_SEL_BIT]);
  assign cs0_pin_select = spm_pkg::bit_role(
    spi_pin_function_select_ff[spm_pkg::CS0_SEL_BIT]);
  assign serial_clock_pin_select = spm_pkg::clk_pair_role(
    spi_pin_function_select_ff[spm_pkg::SCK_SEL_HI:spm_pkg::SCK_SEL_LO]
  );
  assign data_in_pin_select = spm_pkg::clk_pair_role(
    spi_pin_function_select_ff[spm_pkg::DIN_SEL_HI:spm_pkg::DIN_SEL_LO]
  );
  assign data_out_pin_select = spm_pkg::bit_role(
    spi_pin_function_select_ff[spm_pkg::DOUT_SEL_BIT]);

  // pins handed to a peripheral, shown in the pin state register
  assign func_mask = {
    cs3_pin_select != spm_pkg::ROLE_GPIO,
    cs2_pin_select != spm_pkg::ROLE_GPIO,
    cs1_pin_select != spm_pkg::ROLE_GPIO,
    cs0_pin_select != spm_pkg::ROLE_GPIO,
    serial_clock_pin_select != spm_pkg::ROLE_GPIO,
    data_in_pin_select != spm_pkg::ROLE_GPIO,
    data_out_pin_select != spm_pkg::ROLE_GPIO
  };

  // ---------------------------------------------------------------
  // output multiplexers
  // ---------------------------------------------------------------

  // default every pad to its gpio registers, then override by role
  always_comb begin
    nxt_level = gpio_data_ff;
    nxt_drive = gpio_dir_ff;
    // chip select 3: dma ack, pulse output or spi select
    case (cs3_pin_select)
      spm_pkg::ROLE_ALT_A: begin
        nxt_level[spm_pkg::PIN_CS3] = dma_acknowledge_3;
        nxt_drive[spm_pkg::PIN_CS3] = 1'b1;
      end
      spm_pkg::ROLE_ALT_B: begin
        nxt_level[spm_pkg::PIN_CS3] = pulse_output_3;
        nxt_drive[spm_pkg::PIN_CS3] = 1'b1;
      end
      spm_pkg::ROLE_SPI: begin
        nxt_level[spm_pkg::PIN_CS3] = spi_chip_select_3;
        nxt_drive[spm_pkg::PIN_CS3] = 1'b1;
      end
      default: begin
      end
    endcase
    // chip select 2: same choices as chip select 3
    case (cs2_pin_select)
      spm_pkg::ROLE_ALT_A: begin
        nxt_level[spm_pkg::PIN_CS2] = dma_acknowledge_2;
        nxt_drive[spm_pkg::PIN_CS2] = 1'b1;
      end
      spm_pkg::ROLE_ALT_B: begin
        nxt_level[spm_pkg::PIN_CS2] = pulse_output_2;
        nxt_drive[spm_pkg::PIN_CS2] = 1'b1;
      end
      spm_pkg::ROLE_SPI: begin
        nxt_level[spm_pkg::PIN_CS2] = spi_chip_select_2;
        nxt_drive[spm_pkg::PIN_CS2] = 1'b1;
      end
      default: begin
      end
    endcase
    // chip selects 1 and 0
    if (cs1_pin_select == spm_pkg::ROLE_SPI) begin
      nxt_level[spm_pkg::PIN_CS1] = spi_chip_select_1;
      nxt_drive[spm_pkg::PIN_CS1] = 1'b1;
    end
    if (cs0_pin_select == spm_pkg::ROLE_SPI) begin
      nxt_level[spm_pkg::PIN_CS0] = spi_chip_select_0;
      nxt_drive[spm_pkg::PIN_CS0] = 1'b1;
    end
    // serial clock: i2c clock is open drain, only ever pulled low
    case (serial_clock_pin_select)
      spm_pkg::ROLE_ALT_B: begin
        nxt_level[spm_pkg::PIN_SCK] = 1'b0;
        nxt_drive[spm_pkg::PIN_SCK] = i2c_scl_drive_low;
      end
      spm_pkg::ROLE_SPI: begin
        nxt_level[spm_pkg::PIN_SCK] = spi_clock_out;
        nxt_drive[spm_pkg::PIN_SCK] = 1'b1;
      end
      default: begin
      end
    endcase
    // data in: i2c data is open drain, spi data in is input only
    case (data_in_pin_select)
      spm_pkg::ROLE_ALT_B: begin
        nxt_level[spm_pkg::PIN_DIN] = 1'b0;
        nxt_drive[spm_pkg::PIN_DIN] = i2c_sda_drive_low;
      end
      spm_pkg::ROLE_SPI: begin
        nxt_level[spm_pkg::PIN_DIN] = 1'b0;
        nxt_drive[spm_pkg::PIN_DIN] = 1'b0;
      end
      default: begin
      end
    endcase
    // data out
    if (data_out_pin_select == spm_pkg::ROLE_SPI) begin
      nxt_level[spm_pkg::PIN_DOUT] = spi_data_out;
      nxt_drive[spm_pkg::PIN_DOUT] = 1'b1;
    end
  end

  // one registered output stage per pad
  for (genvar i = 0; i < spm_pkg::PIN_N; i++) begin : g_pad
    spm_pin_cell u_cell (
      .clock(clock),
      .rst_n(rst_n),
      .ce(ce),
      .nxt_level(nxt_level[i]),
      .nxt_drive(nxt_drive[i]),
      .pin_out(pin_out[i]),
      .pin_oe_n(pin_oe_n[i])
    );
  end

  // ---------------------------------------------------------------
  // input path
  // ---------------------------------------------------------------

  // pads are asynchronous to the system clock
  spm_sync2 #(
    .WIDTH(spm_pkg::PIN_N)
  ) u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .ce(ce),
    .async_in(pin_in),
    .sync_out(pin_sync)
  );

  // peripheral inputs see the pad only while they own it; idle i2c
  // lines read high so a deselected bus looks released
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      spi_data_in_ff <= 1'b0;
      i2c_scl_in_ff <= 1'b1;
      i2c_sda_in_ff <= 1'b1;
    end else if (ce) begin
      spi_data_in_ff <= (data_in_pin_select == spm_pkg::ROLE_SPI) &
                        pin_sync[spm_pkg::PIN_DIN];
      i2c_scl_in_ff <= (serial_clock_pin_select != spm_pkg::ROLE_ALT_B) |
                       pin_sync[spm_pkg::PIN_SCK];
      i2c_sda_in_ff <= (data_in_pin_select != spm_pkg::ROLE_ALT_B) |
                       pin_sync[spm_pkg::PIN_DIN];
    end
  end

  assign spi_data_in = spi_data_in_ff;
  assign i2c_scl_in = i2c_scl_in_ff;
  assign i2c_sda_in = i2c_sda_in_ff;

endmodule : spm_pin_mux

/* File: core/spm_sync2.sv */
`timescale 1ns/1ps
// two-stage synchroniser for pin levels
module spm_sync2 #(
  parameter int WIDTH = 7
) (
  input wire logic clock, // system clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic ce, // clock enable
  input wire logic [WIDTH-1:0] async_in, // raw pin levels
  output logic [WIDTH-1:0] sync_out // levels safe to use
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  // first stage is read only by the second stage
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else if (ce) begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule : spm_sync2

/* File: include/spm_pkg.sv */
package spm_pkg;

  // register geometry
  localparam int REG_W = 16;
  localparam int PIN_N = 7;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;

  // byte offsets on the register bus
  localparam logic [3:0] OFS_FUNC_SEL = 4'h0;
  localparam logic [3:0] OFS_GPIO_DATA = 4'h4;
  localparam logic [3:0] OFS_GPIO_DIR = 4'h8;
  localparam logic [3:0] OFS_PIN_STATE = 4'hC;

  // field positions inside the function select register
  localparam int CS3_SEL_HI = 13;
  localparam int CS3_SEL_LO = 12;
  localparam int CS2_SEL_HI = 11;
  localparam int CS2_SEL_LO = 10;
  localparam int CS1_SEL_BIT = 9;
  localparam int CS0_SEL_BIT = 7;
  localparam int SCK_SEL_HI = 5;
  localparam int SCK_SEL_LO = 4;
  localparam int DIN_SEL_HI = 3;
  localparam int DIN_SEL_LO = 2;
  localparam int DOUT_SEL_BIT = 1;

  // writable bits; reserved 15:14, 8, 6 and 0 stay zero
  localparam logic [15:0] FUNC_SEL_WMASK = 16'h3EBE;

  // values after reset
  localparam logic [15:0] FUNC_SEL_RESET = 16'h0000;
  localparam logic [6:0] GPIO_DATA_RESET = 7'h00;
  localparam logic [6:0] GPIO_DIR_RESET = 7'h00;
  localparam logic [31:0] READ_DATA_RESET = 32'h0000_0000;

  // pin index within the pin vectors
  localparam int PIN_DOUT = 0;
  localparam int PIN_DIN = 1;
  localparam int PIN_SCK = 2;
  localparam int PIN_CS0 = 3;
  localparam int PIN_CS1 = 4;
  localparam int PIN_CS2 = 5;
  localparam int PIN_CS3 = 6;

  // role that a pin takes; alt_a and alt_b depend on the pin
  typedef enum logic [1:0] {
    ROLE_GPIO,
    ROLE_ALT_A,
    ROLE_ALT_B,
    ROLE_SPI
  } spm_role_t;

  // chip-select pair code: gpio, dma ack, pulse out, spi
  function automatic spm_role_t cs_pair_role(input logic [1:0] code);
    case (code)
      2'b00: cs_pair_role = ROLE_GPIO;
      2'b01: cs_pair_role = ROLE_ALT_A;
      2'b10: cs_pair_role = ROLE_ALT_B;
      default: cs_pair_role = ROLE_SPI;
    endcase
  endfunction : cs_pair_role

  // clock/data-in code: 00 and 01 both gpio, 10 i2c, 11 spi
  function automatic spm_role_t clk_pair_role(input logic [1:0] code);
    case (code)
      2'b10: clk_pair_role = ROLE_ALT_B;
      2'b11: clk_pair_role = ROLE_SPI;
      default: clk_pair_role = ROLE_GPIO;
    endcase
  endfunction : clk_pair_role

  // single-bit selector: gpio or spi
  function automatic spm_role_t bit_role(input logic sel);
    bit_role = sel ? ROLE_SPI : ROLE_GPIO;
  endfunction : bit_role

  // merge the two low byte lanes of a write into a 16-bit value
  function automatic logic [15:0] lane_merge(input logic [15:0] old_val,
                                             input logic [31:0] wdata,
                                             input logic [3:0] be);
    lane_merge = old_val;
    if (be[0]) begin
      lane_merge[7:0] = wdata[7:0];
    end
    if (be[1]) begin
      lane_merge[15:8] = wdata[15:8];
    end
  endfunction : lane_merge

endpackage : spm_pkg
